// ==== aapr_pkg.sv ====
// Constants and carrier types for the auto-negotiation advertisement and partner ability registers.
// Assumes a management front end that delivers decoded register reads and writes on core_clk.
// Functional notes
// RULE1 - Advertisement word lives at offset 0x4 and resets to 0x1E1.
// RULE2 - Advertisement bit 15 is read-write, resets 0, requests next page transfer.
// RULE3 - Software keeps advertisement bit 13 clear; remote fault is unsupported.
// RULE4 - Advertisement bit 11 is read-write, resets 0, advertises asymmetric pause.
// RULE5 - Advertisement bit 10 is read-write, resets 0, advertises symmetric pause.
// RULE6 - Advertisement bit 9 resets 0 and advertises 100BASE-T4 when set.
// RULE7 - Advertisement bits 8 to 5 are read-write, reset 1, the four duplex abilities.
// RULE8 - In forced mode the four duplex ability bits are ignored.
// RULE9 - Bits 8 to 5 take their reset value from the negotiation disable strap.
// RULE10 - Bits 4 to 0 are a read-write selector field resetting to 00001.
// RULE11 - Partner ability word lives at offset 0x5 and resets to zero.
// RULE12 - Partner bit 15 shows the remote next page request.
// RULE13 - Partner bit 14 shows the remote acknowledge of our code word.
// RULE14 - Partner bit 13 shows the remote fault advertised by the remote station.
// RULE15 - Partner bits 11 to 5 show remote pause, T4 and duplex abilities.
// RULE16 - Reserved bits 14 and 12 of advertisement and 12 of partner read zero.
// RULE17 - Partner register is read-only and reloads on every received base page.
package aapr_pkg;

  localparam logic [4:0]  ADDR_ADVERT     = 5'h04;
  localparam logic [4:0]  ADDR_PARTNER    = 5'h05;
  localparam logic [15:0] ADVERT_RESET    = 16'h01e1;
  localparam logic [15:0] PARTNER_RESET   = 16'h0000;
  // Writable advertisement bits: all but the reserved bits 14 and 12.
  localparam logic [15:0] ADVERT_WR_MASK  = 16'hafff;
  // Stored partner bits: all but reserved bit 12.
  localparam logic [15:0] PARTNER_MASK    = 16'hefff;
  // The four 10/100 duplex ability bits, 8 down to 5.
  localparam logic [15:0] ABILITY_MASK    = 16'h01e0;
  localparam int          ABILITY_LSB     = 5;
  localparam int          NEXT_PAGE_BIT   = 15;
  localparam int          STRAP_SYNC_LEN  = 3;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wrData;
  } aapr_mgmt_req_t;

  typedef struct packed {
    logic [STRAP_SYNC_LEN-1:0] strapSync;
    logic [STRAP_SYNC_LEN-1:0] strapFill;
    logic                      strapLoaded;
    logic [15:0]               advert;
    logic [15:0]               partner;
    logic [15:0]               rdData;
    logic [15:0]               txWord;
  } aapr_state_t;

endpackage : aapr_pkg

// ==== aapr_regs.sv ====
// Advertisement and partner ability registers of the auto-negotiation unit.
// Assumes the serial management logic decodes frames into one-cycle read and write strobes,
// and the negotiation logic pulses pageValid once per received base page.
`timescale 1ns/1ps
module aapr_regs (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire aapr_pkg::aapr_mgmt_req_t mgmtReq,
  output      logic [15:0]             mgmtRdData,
  input  wire logic                    negotiationDisableStrap,
  input  wire logic                    forcedMode,
  input  wire logic                    pageValid,
  input  wire logic [15:0]             pageWord,
  output      logic [15:0]             localAdvertWord,
  output      logic [15:0]             txAdvertWord,
  output      logic [15:0]             partnerAbilityWord
);

  localparam int ABL_HI = aapr_pkg::ABILITY_LSB + 3;

  // The logic indexes a three-stage strap chain and four adjacent, writable duplex bits.
  // Constants that break either assumption are refused rather than left to mis-wire the strap.
  if (aapr_pkg::STRAP_SYNC_LEN != 3) begin : g_bad_sync_len
    $error("strap synchroniser must be three stages long");
  end
  if (aapr_pkg::ABILITY_MASK != (16'h000f << aapr_pkg::ABILITY_LSB)) begin : g_bad_ability_mask
    $error("duplex ability mask does not match its low bit");
  end
  if ((aapr_pkg::ABILITY_MASK & ~aapr_pkg::ADVERT_WR_MASK) != 16'h0000) begin : g_bad_write_mask
    $error("duplex ability bits must be writable");
  end
  if (aapr_pkg::PARTNER_MASK[15:13] != 3'h7) begin : g_bad_partner_mask
    $error("partner status bits must be stored");
  end

  localparam aapr_pkg::aapr_state_t STATE_RESET = '{
    strapSync:   '0,
    strapFill:   '0,
    strapLoaded: 1'b0,
    advert:      aapr_pkg::ADVERT_RESET,
    partner:     aapr_pkg::PARTNER_RESET,
    rdData:      16'h0000,
    txWord:      aapr_pkg::ADVERT_RESET
  };

  aapr_pkg::aapr_state_t st;
  aapr_pkg::aapr_state_t next_st;
  logic                  advWrite;
  logic                  strapTake;

  assign advWrite  = mgmtReq.wr && (mgmtReq.addr == aapr_pkg::ADDR_ADVERT);
  // The strap is taken once, after the chain has filled and its second and third stages agree.
  // Without the fill count the all-zero reset contents of the chain would pass for a low strap
  // at the first edge after reset, and a high strap would never be seen.
  assign strapTake = st.strapFill[2] && !st.strapLoaded && (st.strapSync[1] == st.strapSync[2]);

  always_comb begin
    next_st           = st;
    next_st.strapSync = {st.strapSync[1:0], negotiationDisableStrap};
    next_st.strapFill = {st.strapFill[1:0], 1'b1};
    // A strapped-off negotiation clears the duplex abilities; a later software write still wins.
    if (strapTake) begin
      next_st.strapLoaded = 1'b1;
      next_st.advert[ABL_HI:aapr_pkg::ABILITY_LSB] = {4{~st.strapSync[2]}}; // see RULE9
    end
    // Bits 15, 13, 11..0 are stored as written, so pause, T4, duplex and selector all land here.
    if (advWrite) begin
      next_st.advert = mgmtReq.wrData & aapr_pkg::ADVERT_WR_MASK; // see RULE1
      // see RULE2 see RULE4 see RULE5 see RULE6 see RULE7 see RULE10 see RULE16
    end
    // Remote fault is stored verbatim; keeping it clear is left to software.
    // see RULE3
    // Writes to the partner offset fall through untouched because that word is read-only.
    if (pageValid) begin
      next_st.partner = pageWord & aapr_pkg::PARTNER_MASK; // see RULE17
      // see RULE12 see RULE13 see RULE14 see RULE15
    end
    if (mgmtReq.rd) begin
      unique case (mgmtReq.addr)
        aapr_pkg::ADDR_ADVERT:  next_st.rdData = st.advert;
        aapr_pkg::ADDR_PARTNER: next_st.rdData = st.partner; // see RULE11
        default:                next_st.rdData = 16'h0000;
      endcase
    end
    // The word sent to the remote station drops the duplex abilities when speed is forced.
    if (forcedMode) begin
      next_st.txWord = st.advert & ~aapr_pkg::ABILITY_MASK; // see RULE8
    end else begin
      next_st.txWord = st.advert;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign mgmtRdData         = st.rdData;
  assign localAdvertWord    = st.advert;
  assign txAdvertWord       = st.txWord;
  assign partnerAbilityWord = st.partner;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_adv_write_store: assert property (advWrite |=> st.advert == ($past(mgmtReq.wrData) & 16'hafff)) // see RULE1
    else $error("advertisement write not stored");
  a_adv_reserved_zero: assert property (!st.advert[14] && !st.advert[12] && !st.partner[12]) // see RULE16
    else $error("reserved bit reads nonzero");
  a_partner_read_only: assert property (!pageValid |=> $stable(st.partner)) // see RULE17
    else $error("partner word changed without a page");
  a_partner_page_load: assert property (pageValid |=> st.partner == ($past(pageWord) & 16'hefff)) // see RULE11
    else $error("partner word not loaded from page");
  a_forced_ability_off: assert property (forcedMode |=> st.txWord[8:5] == 4'h0) // see RULE8
    else $error("duplex abilities sent in forced mode");
  a_strap_load_value: assert property ( // see RULE9
    strapTake && !advWrite |=> st.advert[8:5] == {4{~$past(st.strapSync[2])}})
    else $error("strap not applied to duplex abilities");
  a_strap_once: assert property (st.strapLoaded |=> st.strapLoaded) // see RULE9
    else $error("strap capture flag dropped");
  a_read_advert_data: assert property ( // see RULE1
    mgmtReq.rd && mgmtReq.addr == 5'h04 |=> mgmtRdData == $past(st.advert))
    else $error("advertisement read returned wrong data");
  a_read_unmapped_zero: assert property (mgmtReq.rd && mgmtReq.addr != 5'h04 && mgmtReq.addr != 5'h05 // see RULE11
                                         |=> mgmtRdData == 16'h0000)
    else $error("unmapped read not zero");
  a_tx_next_page: assert property (!forcedMode |=> st.txWord[15] == $past(st.advert[15])) // see RULE2
    else $error("next page request not sent");

  // Refused writes leave both words alone, and read data stands until the next read.
  a_read_partner_data: assert property ( // see RULE11
    mgmtReq.rd && mgmtReq.addr == aapr_pkg::ADDR_PARTNER |=> mgmtRdData == $past(st.partner))
    else $error("partner read returned wrong data");
  a_read_data_hold: assert property ( // see RULE11
    !mgmtReq.rd |=> $stable(mgmtRdData))
    else $error("read data changed without a read");
  a_advert_hold: assert property ( // see RULE1
    !advWrite && !strapTake |=> $stable(st.advert))
    else $error("advertisement word changed without a write");
  a_unmapped_write_ignored: assert property ( // see RULE1
    mgmtReq.wr && mgmtReq.addr != aapr_pkg::ADDR_ADVERT && !strapTake |=> $stable(localAdvertWord))
    else $error("write to another offset reached the advertisement word");
  a_partner_write_ignored: assert property ( // see RULE17
    mgmtReq.wr && mgmtReq.addr == aapr_pkg::ADDR_PARTNER && !pageValid |=> $stable(partnerAbilityWord))
    else $error("software write reached the partner word");
  a_tx_follows_advert: assert property ( // see RULE8
    !forcedMode |=> txAdvertWord == $past(st.advert))
    else $error("sent word differs from the advertisement outside forced mode");
  a_forced_keeps_rest: assert property ( // see RULE8
    forcedMode |=> (txAdvertWord & ~aapr_pkg::ABILITY_MASK) == ($past(st.advert) & ~aapr_pkg::ABILITY_MASK))
    else $error("forced mode disturbed bits other than the duplex abilities");
  a_partner_next_page: assert property ( // see RULE12
    pageValid |=> partnerAbilityWord[15] == $past(pageWord[15]))
    else $error("partner next page request not reported");
  a_partner_acknowledge: assert property ( // see RULE13
    pageValid |=> partnerAbilityWord[14] == $past(pageWord[14]))
    else $error("partner acknowledge not reported");
  a_partner_fault: assert property ( // see RULE14
    pageValid |=> partnerAbilityWord[13] == $past(pageWord[13]))
    else $error("partner remote fault not reported");
  // A capture straight after reset would read the chain's reset value instead of the pin.
  a_strap_after_fill: assert property ( // see RULE9
    strapTake |-> $past(reset_n, 3))
    else $error("strap taken before the synchroniser filled");
  a_strap_keeps_rest: assert property ( // see RULE9
    strapTake && !advWrite |=> (st.advert & ~aapr_pkg::ABILITY_MASK) == ($past(st.advert) & ~aapr_pkg::ABILITY_MASK))
    else $error("strap disturbed bits other than the duplex abilities");
  // Checked without the reset filter, since this one is about what reset itself does.
  a_reset_values: assert property (@(posedge core_clk) disable iff (1'b0) // see RULE1
    !reset_n ##1 !reset_n |-> st == STATE_RESET)
    else $error("state not at its reset value during reset");

  // Writable advertisement bits follow the bus; reserved bits never leave zero.
  for (genvar b = 0; b < 16; b = b + 1) begin : g_advert_bit
    if (aapr_pkg::ADVERT_WR_MASK[b]) begin : g_writable
      a_adv_bit_written: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE10
        advWrite |=> localAdvertWord[b] == $past(mgmtReq.wrData[b]))
        else $error("writable advertisement bit not stored");
    end else begin : g_reserved
      a_adv_bit_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE16
        !localAdvertWord[b])
        else $error("reserved advertisement bit reads nonzero");
    end
  end

  // A received page lands bit for bit, except for the reserved position.
  for (genvar b = 0; b < 16; b = b + 1) begin : g_partner_bit
    if (aapr_pkg::PARTNER_MASK[b]) begin : g_stored
      a_partner_bit_copy: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE15
        pageValid |=> partnerAbilityWord[b] == $past(pageWord[b]))
        else $error("partner ability bit not taken from the page");
    end else begin : g_reserved
      a_partner_bit_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE16
        !partnerAbilityWord[b])
        else $error("reserved partner bit reads nonzero");
    end
  end

  // Forced speed drops only the four duplex abilities from the sent word; every other bit passes.
  for (genvar b = 0; b < 16; b = b + 1) begin : g_tx_bit
    if (aapr_pkg::ABILITY_MASK[b]) begin : g_gated
      a_tx_ability_gate: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE8
        1'b1 |=> txAdvertWord[b] == (!$past(forcedMode) && $past(st.advert[b])))
        else $error("duplex ability bit not gated by forced mode");
    end else begin : g_plain
      a_tx_bit_copy: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE2
        1'b1 |=> txAdvertWord[b] == $past(st.advert[b]))
        else $error("advertisement bit not passed to the sent word");
    end
  end

  // Each duplex ability bit takes the inverse of the settled strap unless software writes in the same cycle.
  for (genvar b = aapr_pkg::ABILITY_LSB; b <= ABL_HI; b = b + 1) begin : g_strap_bit
    a_strap_bit_value: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE9
      strapTake && !advWrite |=> localAdvertWord[b] == !$past(st.strapSync[2]))
      else $error("strap not applied to a duplex ability bit");
  end

  c_adv_write: cover property (advWrite ##1 mgmtReq.rd && mgmtReq.addr == 5'h04);
  c_page_read: cover property (pageValid ##[1:4] mgmtReq.rd && mgmtReq.addr == 5'h05);
  c_forced_mode: cover property (forcedMode && st.advert[8:5] != 4'h0);
  c_strap_high: cover property (strapTake && st.strapSync[2]);
  c_back_to_back: cover property (advWrite ##1 advWrite);

endmodule : aapr_regs

// ==== aapr_link_partner.sv ====
// Remote station model that delivers received base pages to the register block.
// Assumes it shares core_clk with the block and changes its outputs on the falling edge.
`timescale 1ns/1ps
module aapr_link_partner (
  input  wire logic        core_clk,
  output      logic        pageValid,
  output      logic [15:0] pageWord
);
  initial begin
    pageValid = 1'b0;
    pageWord  = 16'h0000;
  end
  // After the pulse the word is inverted, so stale data can never pass for a fresh page.
  task automatic send(input logic [15:0] w);
    @(negedge core_clk);
    pageValid = 1'b1;
    pageWord  = w;
    @(negedge core_clk);
    pageValid = 1'b0;
    pageWord  = ~w;
  endtask : send
endmodule : aapr_link_partner

// ==== aapr_regs_tb.sv ====
// Self-checking bench for the advertisement and partner ability registers.
// Assumes decoded one-cycle management strobes and a link partner model for pages.
`timescale 1ns/1ps
module aapr_regs_tb;
  logic                     core_clk = 1'b0;
  logic                     reset_n = 1'b0;
  aapr_pkg::aapr_mgmt_req_t mgmtReq = '0;
  logic                     negotiationDisableStrap = 1'b0;
  logic                     forcedMode = 1'b0;
  logic                     pageValid;
  logic [15:0]              pageWord, mgmtRdData, localAdvertWord, txAdvertWord, partnerAbilityWord;
  int                       error_cnt = 0;
  int                       checks_done = 0;
  int                       cyc = 0;
  aapr_regs i_aapr_regs (.core_clk(core_clk), .reset_n(reset_n), .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData),
    .negotiationDisableStrap(negotiationDisableStrap), .forcedMode(forcedMode), .pageValid(pageValid),
    .pageWord(pageWord), .localAdvertWord(localAdvertWord), .txAdvertWord(txAdvertWord),
    .partnerAbilityWord(partnerAbilityWord));
  aapr_link_partner i_aapr_link_partner (.core_clk(core_clk), .pageValid(pageValid), .pageWord(pageWord));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // A hung run is charged as a mismatch.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic cmp(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic acc(input logic r, input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    mgmtReq = '{r, ~r, a, d};
    @(negedge core_clk);
    mgmtReq = '0;
  endtask : acc
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    acc(1'b1, a, 16'h0000);
    cmp("mgmtRdData", mgmtRdData, e);
  endtask : rd_chk
  // The strap settles through its synchroniser well within the six idle cycles.
  task automatic rst();
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask : rst
  initial begin
    rst();
    cmp("localAdvertWord", localAdvertWord, 16'h01e1);
    rd_chk(5'h04, 16'h01e1);
    rd_chk(5'h05, 16'h0000);
    acc(1'b0, 5'h04, 16'hdfff);
    rd_chk(5'h04, 16'h8fff);
    acc(1'b0, 5'h04, 16'h0000);
    rd_chk(5'h04, 16'h0000);
    acc(1'b0, 5'h05, 16'hffff);
    rd_chk(5'h05, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    i_aapr_link_partner.send(16'hffff);
    cmp("partnerAbilityWord", partnerAbilityWord, 16'hefff);
    rd_chk(5'h05, 16'hefff);
    i_aapr_link_partner.send(16'h4a21);
    rd_chk(5'h05, 16'h4a21);
    acc(1'b0, 5'h04, 16'h01e1);
    forcedMode = 1'b1;
    repeat (2) @(negedge core_clk);
    cmp("txAdvertWord", txAdvertWord, 16'h0001);
    cmp("localAdvertWord", localAdvertWord, 16'h01e1);
    forcedMode = 1'b0;
    repeat (2) @(negedge core_clk);
    cmp("txAdvertWord", txAdvertWord, 16'h01e1);
    negotiationDisableStrap = 1'b1;
    rst();
    cmp("localAdvertWord", localAdvertWord, 16'h0001);
    cmp("txAdvertWord", txAdvertWord, 16'h0001);
    cmp("partnerAbilityWord", partnerAbilityWord, 16'h0000);
    end_sim();
  end
endmodule : aapr_regs_tb
